/* File: design/erc_access_check.sv */
// Purpose: Decides whether a register access goes ahead, is undefined or traps.
// Assumes: Exception level and hypervisor controls are stable with the request.
// Notes: Purely combinational; the top registers its result.
`default_nettype none

module erc_access_check (
  // Privilege context.
  input wire logic [1:0] exc_level,
  input wire logic hyp_enabled,
  input wire logic ras_trap_ctrl,
  // Outcome.
  output var erc_pkg::erc_acc_type outcome
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic erc_pkg::erc_acc_type judge(
    input logic [1:0] lvl,
    input logic hyp,
    input logic trp
  );
    erc_pkg::erc_acc_type r;
    r = erc_pkg::ACC_OK;
    if (lvl == 2'h0)
    begin
      r = erc_pkg::ACC_UNDEF;
    end
    else if (lvl == 2'h1 && hyp && trp)
    begin
      r = erc_pkg::ACC_TRAP;
    end
    return r;
  endfunction

  assign outcome = judge(exc_level, hyp_enabled, ras_trap_ctrl);

endmodule // erc_access_check

`default_nettype wire

/* File: design/erc_pkg.sv */
// Purpose: Constants and types for the error record control and status block.
// Assumes: One record; system-register style access with 64-bit data.
// Notes: Control enables come out of reset at zero.
`default_nettype none

package erc_pkg;

  // Register selector carried with each access.
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_MISC0 = 3'h2;

  // Control field positions.
  localparam int CTL_CRIT = 13;
  localparam int CTL_POSTPONE = 10;
  localparam int CTL_OVF = 8;
  localparam int CTL_FAULT = 3;
  localparam int CTL_RECOV = 2;
  localparam int CTL_LOG = 0;

  // Status field positions.
  localparam int ST_ADDR = 31;
  localparam int ST_VALID = 30;
  localparam int ST_UNFIXED = 29;
  localparam int ST_INBAND = 28;
  localparam int ST_LOST = 27;
  localparam int ST_MISC = 26;
  localparam int ST_CE_HI = 25;
  localparam int ST_CE_LO = 24;
  localparam int ST_POSTPONED = 23;
  localparam int ST_CRIT = 19;

  // Values after reset and field codes.
  localparam logic CTL_RESET = 1'b0;
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_SEEN = 2'h2;
  localparam logic [1:0] CE_CLEAR = 2'h3;
  localparam logic [5:0] TRAP_CLASS = 6'h18;

  // Error class of a detected error.
  typedef enum logic [2:0] {
    ERR_CORRECTED = 3'b001,
    ERR_DEFERRED = 3'b010,
    ERR_UNFIXED = 3'b100
  } erc_err_type;

  // Outcome of a register access.
  typedef enum logic [2:0] {
    ACC_OK = 3'b001,
    ACC_UNDEF = 3'b010,
    ACC_TRAP = 3'b100
  } erc_acc_type;

endpackage

`default_nettype wire

/* File: design/erc_record.sv */
// Purpose: Control and primary status of the first error record, with interrupts.
// Assumes: One access per request pulse; error events are one-cycle pulses.
// Notes: Answers come one cycle after the request, from flip-flops.
//
// How it works
// - Critical enable set: critical flag raises the critical interrupt.
// - Deferred-error recovery enable is read-only; writes never change it.
// - Overflow enable set: counter overflow raises the fault interrupt.
// - Fault enable set: any recorded error class raises the fault interrupt.
// - Recovery enable set: uncorrected, non-deferred error raises recovery interrupt.
// - Interrupts still raise when a syndrome is dropped for a higher one.
// - Logging enable clear: no error is recorded or signalled.
// - Control enables have no promised reset value; software programs them.
// - Address-valid and in-band bits read zero and ignore writes.
// - Valid sets on any recorded error; reset zero; write one clears.
// - Uncorrected flag sets on a non-fixed, non-deferred error; write one clears.
// - Lost flag sets on counter overflow or non-corrected error while valid.
// - Direct writes may leave counter and lost flags out of step.
// - Misc flag marks first misc register valid; others read zero.
// - Corrected field reads 00 or 10; writing 11 clears it.
// - Deferred flag sets on a deferred error; write one clears.
// - With valid clear, the class flags carry no meaning.
// - Accesses from the least privileged level are undefined.
// - First level with hypervisor enabled and trap control set traps, class 0x18.
// - Registers alias the record only while record select is zero.
`default_nettype none

module erc_record (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access request.
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [2:0] acc_sel,
  input wire logic [63:0] acc_wdata,
  input wire logic [15:0] record_select,
  input wire logic [1:0] exc_level,
  input wire logic hyp_enabled,
  input wire logic ras_trap_ctrl,
  // Register access answer.
  output logic acc_done_q,
  output logic acc_undef_q,
  output logic acc_trap_q,
  output logic [5:0] trap_class_q,
  output logic [63:0] acc_rdata_q,
  // Detected errors.
  input wire logic err_valid,
  input wire erc_pkg::erc_err_type err_kind,
  input wire logic err_critical,
  input wire logic err_misc,
  input wire logic ce_ovf,
  input wire logic [63:0] first_misc_info,
  // Interrupts.
  output logic critical_irq_q,
  output logic fault_irq_q,
  output logic recovery_irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  erc_pkg::erc_acc_type outcome;
  logic sel_ok;
  logic acc_go;
  logic wr_ctrl;
  logic wr_status;

  erc_access_check u_check (
    .exc_level(exc_level),
    .hyp_enabled(hyp_enabled),
    .ras_trap_ctrl(ras_trap_ctrl),
    .outcome(outcome)
  );

  assign sel_ok = (record_select == 16'h0000);
  assign acc_go = acc_req && (outcome == erc_pkg::ACC_OK);
  assign wr_ctrl = acc_go && acc_write && sel_ok && (acc_sel == erc_pkg::SEL_CTRL);
  assign wr_status = acc_go && acc_write && sel_ok && (acc_sel == erc_pkg::SEL_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Control register.

  logic critical_irq_enable_q;
  logic overflow_irq_enable_q;
  logic fault_irq_enable_q;
  logic recovery_irq_enable_q;
  logic report_log_on_q;
  // Deferred-error interrupt is not built, so its enable is a fixed read-only zero.
  localparam logic postponed_irq_enable = 1'b0;

  // Zero is one legal pick of an unspecified reset value; software sets these.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      critical_irq_enable_q <= erc_pkg::CTL_RESET;
      overflow_irq_enable_q <= erc_pkg::CTL_RESET;
      fault_irq_enable_q <= erc_pkg::CTL_RESET;
      recovery_irq_enable_q <= erc_pkg::CTL_RESET;
      report_log_on_q <= erc_pkg::CTL_RESET;
    end
    else if (wr_ctrl)
    begin
      critical_irq_enable_q <= acc_wdata[erc_pkg::CTL_CRIT];
      overflow_irq_enable_q <= acc_wdata[erc_pkg::CTL_OVF];
      fault_irq_enable_q <= acc_wdata[erc_pkg::CTL_FAULT];
      recovery_irq_enable_q <= acc_wdata[erc_pkg::CTL_RECOV];
      report_log_on_q <= acc_wdata[erc_pkg::CTL_LOG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error events, gated by the logging enable.

  logic ev_any;
  logic ev_fixed;
  logic ev_postponed;
  logic ev_unfixed;
  logic ev_ovf;

  assign ev_any = err_valid && report_log_on_q;
  assign ev_fixed = ev_any && (err_kind == erc_pkg::ERR_CORRECTED);
  assign ev_postponed = ev_any && (err_kind == erc_pkg::ERR_DEFERRED);
  assign ev_unfixed = ev_any && (err_kind == erc_pkg::ERR_UNFIXED);
  assign ev_ovf = ce_ovf && report_log_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: write one to clear, and a new event wins over the clear.

  logic valid_q;
  logic unfixed_error_seen_q;
  logic syndrome_lost_q;
  logic misc_regs_ok_q;
  logic [1:0] corrected_q;
  logic postponed_error_seen_q;
  logic critical_seen_q;

  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    return set || (cur && !clr);
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      valid_q <= 1'b0;
      unfixed_error_seen_q <= 1'b0;
      syndrome_lost_q <= 1'b0;
      misc_regs_ok_q <= 1'b0;
      postponed_error_seen_q <= 1'b0;
      critical_seen_q <= 1'b0;
    end
    else
    begin
      valid_q <= w1c(valid_q, ev_any, wr_status && acc_wdata[erc_pkg::ST_VALID]);
      unfixed_error_seen_q <= w1c(unfixed_error_seen_q, ev_unfixed,
                                  wr_status && acc_wdata[erc_pkg::ST_UNFIXED]);
      // Dropped non-corrected syndromes and counter wraps both count as lost.
      // The counter's own overflow flag lives outside, so a direct write here never disturbs it.
      syndrome_lost_q <= w1c(syndrome_lost_q, ev_ovf || (ev_any && !ev_fixed && valid_q),
                             wr_status && acc_wdata[erc_pkg::ST_LOST]);
      misc_regs_ok_q <= w1c(misc_regs_ok_q, ev_any && err_misc,
                            wr_status && acc_wdata[erc_pkg::ST_MISC]);
      postponed_error_seen_q <= w1c(postponed_error_seen_q, ev_postponed,
                                    wr_status && acc_wdata[erc_pkg::ST_POSTPONED]);
      critical_seen_q <= w1c(critical_seen_q, ev_any && err_critical,
                             wr_status && acc_wdata[erc_pkg::ST_CRIT]);
    end
  end

  // Mixed writes to the corrected field leave it unchanged, one legal outcome.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      corrected_q <= erc_pkg::CE_NONE;
    end
    else if (ev_fixed)
    begin
      corrected_q <= erc_pkg::CE_SEEN;
    end
    else if (wr_status && acc_wdata[erc_pkg::ST_CE_HI:erc_pkg::ST_CE_LO] == erc_pkg::CE_CLEAR)
    begin
      corrected_q <= erc_pkg::CE_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt levels.

  // Flags stay set even when a later syndrome is dropped, so the levels still rise.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      critical_irq_q <= 1'b0;
      fault_irq_q <= 1'b0;
      recovery_irq_q <= 1'b0;
    end
    else
    begin
      critical_irq_q <= critical_irq_enable_q && critical_seen_q;
      fault_irq_q <= (fault_irq_enable_q && valid_q)
                     || (overflow_irq_enable_q && syndrome_lost_q);
      recovery_irq_q <= (recovery_irq_enable_q && unfixed_error_seen_q)
                        || (postponed_irq_enable && postponed_error_seen_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and answer.

  logic [63:0] ctrl_word;
  logic [63:0] status_word;
  logic [63:0] rd_word;

  always_comb
  begin
    ctrl_word = 64'h0;
    ctrl_word[erc_pkg::CTL_CRIT] = critical_irq_enable_q;
    ctrl_word[erc_pkg::CTL_POSTPONE] = postponed_irq_enable;
    ctrl_word[erc_pkg::CTL_OVF] = overflow_irq_enable_q;
    ctrl_word[erc_pkg::CTL_FAULT] = fault_irq_enable_q;
    ctrl_word[erc_pkg::CTL_RECOV] = recovery_irq_enable_q;
    ctrl_word[erc_pkg::CTL_LOG] = report_log_on_q;
  end

  // Class flags are shown as held even while valid is clear; any value is allowed.
  always_comb
  begin
    status_word = 64'h0;
    status_word[erc_pkg::ST_ADDR] = 1'b0;
    status_word[erc_pkg::ST_VALID] = valid_q;
    status_word[erc_pkg::ST_UNFIXED] = unfixed_error_seen_q;
    status_word[erc_pkg::ST_INBAND] = 1'b0;
    status_word[erc_pkg::ST_LOST] = syndrome_lost_q;
    status_word[erc_pkg::ST_MISC] = misc_regs_ok_q;
    status_word[erc_pkg::ST_CE_HI:erc_pkg::ST_CE_LO] = corrected_q;
    status_word[erc_pkg::ST_POSTPONED] = postponed_error_seen_q;
    status_word[erc_pkg::ST_CRIT] = critical_seen_q;
  end

  always_comb
  begin
    rd_word = 64'h0;
    if (sel_ok)
    begin
      case (acc_sel)
        erc_pkg::SEL_CTRL: rd_word = ctrl_word;
        erc_pkg::SEL_STATUS: rd_word = status_word;
        erc_pkg::SEL_MISC0: rd_word = first_misc_info;
        default: rd_word = 64'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_done_q <= 1'b0;
      acc_undef_q <= 1'b0;
      acc_trap_q <= 1'b0;
      trap_class_q <= 6'h00;
      acc_rdata_q <= 64'h0;
    end
    else
    begin
      acc_done_q <= acc_req;
      acc_undef_q <= acc_req && (outcome == erc_pkg::ACC_UNDEF);
      acc_trap_q <= acc_req && (outcome == erc_pkg::ACC_TRAP);
      trap_class_q <= (acc_req && outcome == erc_pkg::ACC_TRAP) ? erc_pkg::TRAP_CLASS : 6'h00;
      acc_rdata_q <= (acc_go && !acc_write) ? rd_word : 64'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_unfixed_logged;
    err_valid && report_log_on_q && err_kind == erc_pkg::ERR_UNFIXED;
  endsequence

  sequence s_recov_up;
    recovery_irq_enable_q && !(wr_status && acc_wdata[erc_pkg::ST_UNFIXED]) && !wr_ctrl;
  endsequence

  a_recov_irq_rise: assert property (
    s_unfixed_logged ##0 s_recov_up |-> ##2 recovery_irq_q)
    else $error("recovery interrupt did not rise after uncorrected error");

  a_log_off_quiet: assert property (
    !report_log_on_q && !wr_status && !wr_ctrl |=> $stable(valid_q))
    else $error("valid changed while logging disabled");

  a_valid_sets: assert property (
    err_valid && report_log_on_q |=> valid_q)
    else $error("valid not set after recorded error");

  a_lost_on_second: assert property (
    valid_q && err_valid && report_log_on_q && err_kind != erc_pkg::ERR_CORRECTED |=> syndrome_lost_q)
    else $error("lost flag not set on second non-corrected error");

  a_ce_code: assert property (
    corrected_q == erc_pkg::CE_NONE || corrected_q == erc_pkg::CE_SEEN)
    else $error("corrected field holds an illegal code");

  a_ce_set: assert property (
    ev_fixed |=> corrected_q == erc_pkg::CE_SEEN)
    else $error("corrected field not set after a correction");

  a_ce_clear: assert property (
    wr_status && acc_wdata[erc_pkg::ST_CE_HI:erc_pkg::ST_CE_LO] == erc_pkg::CE_CLEAR && !ev_fixed
    |=> corrected_q == erc_pkg::CE_NONE)
    else $error("corrected field not cleared by writing ones");

  a_undef_low: assert property (
    acc_req && exc_level == 2'h0 |=> acc_undef_q && !acc_trap_q && acc_rdata_q == 64'h0)
    else $error("least privileged access not undefined");

  a_trap_class: assert property (
    acc_trap_q |-> trap_class_q == erc_pkg::TRAP_CLASS && acc_done_q)
    else $error("trap answer without correct class");

  a_status_raz: assert property (
    acc_done_q && $past(acc_sel) == erc_pkg::SEL_STATUS |-> !acc_rdata_q[31] && !acc_rdata_q[28])
    else $error("unimplemented status bits read nonzero");

  a_postpone_ro: assert property (
    acc_done_q && $past(acc_sel) == erc_pkg::SEL_CTRL |-> !acc_rdata_q[erc_pkg::CTL_POSTPONE])
    else $error("deferred interrupt enable reads nonzero");

  a_alias_sel: assert property (
    acc_req && !acc_write && record_select != 16'h0000 |=> acc_rdata_q == 64'h0)
    else $error("non-zero record select returned data");

  a_crit_irq: assert property (
    critical_irq_q |-> $past(critical_irq_enable_q) && $past(critical_seen_q))
    else $error("critical interrupt without enable and flag");

endmodule // erc_record

`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the error record control and status block.
// Assumes: Answers one cycle after a request; interrupts two edges after an event.
// Notes: Inputs change by non-blocking assignment at rising edges only.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic arst_n;
  logic acc_req;
  logic acc_write;
  logic [2:0] acc_sel;
  logic [63:0] acc_wdata;
  logic [15:0] record_select;
  logic [1:0] exc_level;
  logic hyp_enabled;
  logic ras_trap_ctrl;
  logic acc_done_q;
  logic acc_undef_q;
  logic acc_trap_q;
  logic [5:0] trap_class_q;
  logic [63:0] acc_rdata_q;
  logic err_valid;
  erc_pkg::erc_err_type err_kind;
  logic err_critical;
  logic err_misc;
  logic ce_ovf;
  logic [63:0] first_misc_info;
  logic critical_irq_q;
  logic fault_irq_q;
  logic recovery_irq_q;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [63:0] rq;

  erc_record uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .acc_req(acc_req), .acc_write(acc_write),
    .acc_sel(acc_sel), .acc_wdata(acc_wdata), .record_select(record_select),
    .exc_level(exc_level), .hyp_enabled(hyp_enabled), .ras_trap_ctrl(ras_trap_ctrl),
    .acc_done_q(acc_done_q), .acc_undef_q(acc_undef_q), .acc_trap_q(acc_trap_q),
    .trap_class_q(trap_class_q), .acc_rdata_q(acc_rdata_q), .err_valid(err_valid),
    .err_kind(err_kind), .err_critical(err_critical), .err_misc(err_misc), .ce_ovf(ce_ovf),
    .first_misc_info(first_misc_info), .critical_irq_q(critical_irq_q),
    .fault_irq_q(fault_irq_q), .recovery_irq_q(recovery_irq_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // A hang would otherwise run forever; the sequence needs well under this.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  // One access; the answer stands for the cycle after the taking edge.
  task automatic acc(input logic w, input logic [2:0] s, input logic [63:0] d, input logic [2:0] res);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_sel <= s;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_req <= 1'b0;
    #1;
    rq = acc_rdata_q;
    check_bit(acc_done_q, 1'b1);
    check_bit(acc_undef_q, res[1]);
    check_bit(acc_trap_q, res[2]);
    check_data({58'h0, trap_class_q}, res[2] ? {58'h0, erc_pkg::TRAP_CLASS} : 64'h0);
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [2:0] s, input logic [63:0] exp);
    acc(1'b0, s, 64'h0, 3'h1);
    check_data(rq, exp);
  endtask

  task automatic ev(input erc_pkg::erc_err_type k, input logic crit, input logic misc, input logic ovf);
    err_valid <= 1'b1;
    err_kind <= k;
    err_critical <= crit;
    err_misc <= misc;
    ce_ovf <= ovf;
    @(posedge clk_sys);
    err_valid <= 1'b0;
    ce_ovf <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic irqs(input logic c, input logic f, input logic r);
    #1;
    check_bit(critical_irq_q, c);
    check_bit(fault_irq_q, f);
    check_bit(recovery_irq_q, r);
    @(posedge clk_sys);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_sel = 3'h0;
    acc_wdata = 64'h0;
    record_select = 16'h0;
    exc_level = 2'h1;
    hyp_enabled = 1'b1;
    ras_trap_ctrl = 1'b0;
    err_valid = 1'b0;
    err_kind = erc_pkg::ERR_CORRECTED;
    err_critical = 1'b0;
    err_misc = 1'b0;
    ce_ovf = 1'b0;
    first_misc_info = 64'h0123_4567_89ab_cdef;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(erc_pkg::SEL_CTRL, 64'h0);
    rd(erc_pkg::SEL_STATUS, 64'h0);
    acc(1'b1, erc_pkg::SEL_CTRL, 64'hffff_ffff_ffff_ffff, 3'h1);
    rd(erc_pkg::SEL_CTRL, 64'h210d);
    ev(erc_pkg::ERR_UNFIXED, 1'b0, 1'b1, 1'b0);
    irqs(1'b0, 1'b1, 1'b1);
    rd(erc_pkg::SEL_STATUS, 64'h6400_0000);
    ev(erc_pkg::ERR_DEFERRED, 1'b1, 1'b0, 1'b0);
    irqs(1'b1, 1'b1, 1'b1);
    ev(erc_pkg::ERR_CORRECTED, 1'b0, 1'b0, 1'b0);
    rd(erc_pkg::SEL_STATUS, 64'h6e88_0000);
    acc(1'b1, erc_pkg::SEL_STATUS, 64'h9000_0000, 3'h1);
    rd(erc_pkg::SEL_STATUS, 64'h6e88_0000);
    acc(1'b1, erc_pkg::SEL_STATUS, 64'hffff_ffff, 3'h1);
    irqs(1'b0, 1'b0, 1'b0);
    rd(erc_pkg::SEL_STATUS, 64'h0);
    rd(erc_pkg::SEL_MISC0, 64'h0123_4567_89ab_cdef);
    rd(3'h3, 64'h0);
    // Only the overflow enable and logging: a counter overflow alone must raise the fault line.
    acc(1'b1, erc_pkg::SEL_CTRL, 64'h101, 3'h1);
    ev(erc_pkg::ERR_CORRECTED, 1'b0, 1'b0, 1'b1);
    irqs(1'b0, 1'b1, 1'b0);
    rd(erc_pkg::SEL_STATUS, 64'h4a00_0000);
    acc(1'b1, erc_pkg::SEL_STATUS, 64'hffff_ffff, 3'h1);
    // Fault enable with logging on; a deferred error alone must raise the fault line.
    acc(1'b1, erc_pkg::SEL_CTRL, 64'h9, 3'h1);
    ev(erc_pkg::ERR_DEFERRED, 1'b0, 1'b0, 1'b0);
    irqs(1'b0, 1'b1, 1'b0);
    rd(erc_pkg::SEL_STATUS, 64'h4080_0000);
    acc(1'b1, erc_pkg::SEL_STATUS, 64'hffff_ffff, 3'h1);
    acc(1'b1, erc_pkg::SEL_CTRL, 64'h210c, 3'h1);
    ev(erc_pkg::ERR_UNFIXED, 1'b1, 1'b1, 1'b1);
    irqs(1'b0, 1'b0, 1'b0);
    rd(erc_pkg::SEL_STATUS, 64'h0);
    exc_level <= 2'h0;
    acc(1'b1, erc_pkg::SEL_CTRL, 64'h1, 3'h2);
    exc_level <= 2'h1;
    ras_trap_ctrl <= 1'b1;
    acc(1'b0, erc_pkg::SEL_STATUS, 64'h0, 3'h4);
    check_data(rq, 64'h0);
    ras_trap_ctrl <= 1'b0;
    record_select <= 16'h1;
    acc(1'b1, erc_pkg::SEL_CTRL, 64'h1, 3'h1);
    rd(erc_pkg::SEL_CTRL, 64'h0);
    record_select <= 16'h0;
    rd(erc_pkg::SEL_CTRL, 64'h210c);
    summarize();
  end
endmodule // testbench

`default_nettype wire
